// ### bench/dma_core_model.sv
`timescale 1ns/1ps
// Grants only the lowest request, as a real core does, so each check sees at most one live ack.
module dma_core_model (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic slow_i,
  input wire logic [7:0] dreq_i,
  output logic [7:0] dack_n_o
);
  logic [7:0] d1, d2, g;
  assign g = (slow_i ? d2 : d1) & dreq_i;
  always_ff @(posedge clock_i) begin
    d1 <= srst_i ? 8'h00 : dreq_i;
    d2 <= srst_i ? 8'h00 : d1;
    dack_n_o <= srst_i ? 8'hFF : ~(g & (~g + 8'h01));
  end
endmodule

// ### bench/misc_ctrl_checker.sv
`timescale 1ns/1ps
module misc_ctrl_checker #(
  parameter longint DEB_TICK = 4,
  parameter int DMA_CHANNELS = 8
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire misc_ctrl_pkg::bus_req_t bus_req_i,
  input wire logic bus_rvalid_o,
  input wire logic [DMA_CHANNELS-1:0] ctrl_dack_n_i,
  input wire logic [DMA_CHANNELS-1:0] isa_dack_n_o,
  input wire logic onboard_dma_ack0_n_o,
  input wire logic [15:0] disk_irq_route_o,
  input wire logic general_purpose_pin_o,
  input wire logic general_purpose_pin_oe_o,
  input wire logic io_cycle_valid_i,
  input wire logic io_cycle_subtractive_i,
  input wire logic arbiter_enable_o,
  input wire logic ide_master_allow_o,
  input wire logic [15:0] irq_level_mode_o,
  input wire logic [1:0] isa_clock_sel_o,
  input wire logic isa_bus_clock_en_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);
  a_read_answered: assert property (bus_req_i.rd |=> bus_rvalid_o)
    else $error("read not answered");
  a_answer_cause: assert property (bus_rvalid_o |-> $past(bus_req_i.rd))
    else $error("answer without read");
  a_pair_ack_source: assert property (!onboard_dma_ack0_n_o |-> !(&ctrl_dack_n_i))
    else $error("pair ack without core ack");
  a_isa_ack_masked: assert property ((~isa_dack_n_o & ctrl_dack_n_i) == '0)
    else $error("slot ack without core ack");
  a_route_legal: assert property ($onehot0(disk_irq_route_o)
    && (disk_irq_route_o & 16'h2107) == 16'h0000) else $error("bad disk route");
  a_pin_idle_input: assert property (!general_purpose_pin_oe_o |-> general_purpose_pin_o)
    else $error("pin low in input mode");
  a_pin_low_cause: assert property ($fell(general_purpose_pin_o) |->
    general_purpose_pin_oe_o && $past(io_cycle_valid_i && io_cycle_subtractive_i))
    else $error("pin low without cycle");
  a_arbiter_gate: assert property (!arbiter_enable_o |-> !ide_master_allow_o)
    else $error("disk master runs while off");
  a_fixed_edge: assert property ((irq_level_mode_o & 16'h2107) == 16'h0000)
    else $error("fixed trigger bit set");
  a_clock_off: assert property (isa_clock_sel_o == 2'h3 |-> !isa_bus_clock_en_o)
    else $error("clock enable in code 11");
  a_div4_gap: assert property (isa_clock_sel_o == 2'h1 && isa_bus_clock_en_o |=>
    (!isa_bus_clock_en_o || isa_clock_sel_o != 2'h1) [*3]) else $error("divide by 4 gap");
endmodule

bind system_io_misc_control_regs misc_ctrl_checker #(.DEB_TICK(DEB_TICK),
  .DMA_CHANNELS(DMA_CHANNELS)) chk (.clock_i, .srst_i, .bus_req_i, .bus_rvalid_o,
  .ctrl_dack_n_i, .isa_dack_n_o, .onboard_dma_ack0_n_o, .disk_irq_route_o,
  .general_purpose_pin_o, .general_purpose_pin_oe_o, .io_cycle_valid_i,
  .io_cycle_subtractive_i, .arbiter_enable_o, .ide_master_allow_o, .irq_level_mode_o,
  .isa_clock_sel_o, .isa_bus_clock_en_o);

// ### bench/system_io_misc_control_regs_bench.sv
`timescale 1ns/1ps
module system_io_misc_control_regs_bench;
  logic clock_i, srst_i, bus_rvalid_o, onboard_dma_req0_i, onboard_dma_req1_i;
  logic onboard_dma_ack0_n_o, onboard_dma_ack1_n_o, disk_interrupt_i, general_purpose_pin_i;
  logic general_purpose_pin_o, general_purpose_pin_oe_o, io_cycle_valid_i, slow, en, hit;
  logic io_cycle_subtractive_i, arbiter_enable_o, arbiter_rotating_o, ide_master_allow_o;
  logic rtc_in_use_i, osc_tick_i, isa_bus_clock_en_o, mem_io16_wait_o, flash_write_allowed_o;
  logic nmi_event_i, system_wake_o, monitor_wake_o;
  logic upper_cmos_enable_o, isa_slew_strong_o, pci_buffer_strong_o;
  logic [7:0] bus_rdata_o, isa_dreq_i, ctrl_dack_n_i, ctrl_dreq_o, isa_dack_n_o, cmos_index_i;
  logic [7:0] v, e;
  logic [15:0] disk_irq_route_o, io_cycle_addr_i, irq_level_mode_o, irq_event_i, b, m;
  logic [3:0] io16_recovery_o, io8_recovery_o;
  logic [2:0] ch;
  logic [1:0] isa_clock_sel_o;
  logic [24:0] rst_tab [8] = '{25'h1006200, 25'h1006380, 25'h1006480, 25'h1006580,
    25'h1006602, 25'h1006700, 25'h004D000, 25'h004D100};
  misc_ctrl_pkg::bus_req_t bus_req_i;
  int err_total, cmp_count, n;

  system_io_misc_control_regs #(.DEB_TICK(4)) DUT (.clock_i, .srst_i, .bus_req_i,
    .bus_rdata_o, .bus_rvalid_o, .onboard_dma_req0_i, .onboard_dma_req1_i,
    .onboard_dma_ack0_n_o, .onboard_dma_ack1_n_o, .isa_dreq_i, .ctrl_dack_n_i, .ctrl_dreq_o,
    .isa_dack_n_o, .disk_interrupt_i, .disk_irq_route_o, .general_purpose_pin_i,
    .general_purpose_pin_o, .general_purpose_pin_oe_o, .io_cycle_valid_i,
    .io_cycle_subtractive_i, .io_cycle_addr_i, .arbiter_enable_o, .arbiter_rotating_o,
    .ide_master_allow_o, .rtc_in_use_i, .irq_level_mode_o, .osc_tick_i, .isa_bus_clock_en_o,
    .isa_clock_sel_o, .io16_recovery_o, .io8_recovery_o, .mem_io16_wait_o,
    .flash_write_allowed_o, .upper_cmos_enable_o, .isa_slew_strong_o,
    .pci_buffer_strong_o, .cmos_index_i, .irq_event_i, .nmi_event_i, .system_wake_o,
    .monitor_wake_o);
  dma_core_model core (.clock_i, .srst_i, .slow_i(slow), .dreq_i(ctrl_dreq_o),
    .dack_n_o(ctrl_dack_n_i));

  task automatic end_of_test;
    if (err_total == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic c, input logic w, input logic [15:0] a, input logic [7:0] d);
    @(negedge clock_i);
    bus_req_i = '{c, w, !w, a, d};
    @(negedge clock_i);
    bus_req_i = '0;
  endtask
  task automatic rdc(input logic c, input logic [15:0] a, input logic [7:0] x);
    acc(c, 1'b0, a, 8'h00);
    chk({7'h0, bus_rvalid_o, bus_rdata_o}, {8'h01, x});
  endtask
  task automatic wix(input logic [7:0] i, input logic [7:0] d);
    acc(1'b0, 1'b1, 16'h0022, i);
    acc(1'b0, 1'b1, 16'h0023, d);
  endtask
  task automatic tick(input int k);
    repeat (k) @(negedge clock_i);
  endtask

  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  // A hang is cut short well inside the cycle budget.
  initial begin
    #6000000;
    err_total++;
    end_of_test();
  end
  initial begin
    void'($urandom(32'hE6AF));
    {bus_req_i, onboard_dma_req0_i, onboard_dma_req1_i, isa_dreq_i, disk_interrupt_i} = '0;
    {general_purpose_pin_i, io_cycle_valid_i, io_cycle_subtractive_i, io_cycle_addr_i} = '0;
    {osc_tick_i, irq_event_i, nmi_event_i, slow} = '0;
    rtc_in_use_i = 1'($urandom);
    cmos_index_i = 8'($urandom);
    err_total = 0;
    cmp_count = 0;
    srst_i = 1'b1;
    tick(10);
    srst_i = 1'b0;
    foreach (rst_tab[i]) rdc(rst_tab[i][24], rst_tab[i][23:8], rst_tab[i][7:0]);
    irq_event_i = 16'h0008;
    tick(1);
    chk({14'h0, system_wake_o, monitor_wake_o}, 16'h3);
    for (int i = 8; i < 12; i++) begin
      wix(8'h50 + 8'(i), 8'hFF);
    end
    nmi_event_i = 1'b1;
    irq_event_i = 16'($urandom) | 16'h0008;
    tick(1);
    chk({14'h0, system_wake_o, monitor_wake_o}, 16'h0);
    b = 16'($urandom);
    acc(1'b0, 1'b1, 16'h04D0, b[7:0]);
    acc(1'b0, 1'b1, 16'h04D1, b[15:8]);
    rdc(1'b0, 16'h04D0, b[7:0] & 8'hF8);
    rdc(1'b0, 16'h04D1, b[15:8] & 8'hDE);
    chk(irq_level_mode_o, b & 16'hDEF8);
    v = 8'($urandom);
    wix(8'h54, v);
    rdc(1'b0, 16'h0022, 8'h54);
    rdc(1'b0, 16'h0023, v);
    wix(8'h5F, v);
    rdc(1'b0, 16'h0023, 8'h00);
    wix(8'h55, v);
    rdc(1'b0, 16'h0023, cmos_index_i);
    for (int c = 0; c < 4; c++) begin
      wix(8'h51, {2'(c), 2'(c), 1'b0, c[0], 2'h0});
      chk({12'h0, io16_recovery_o}, 16'(5 - c));
      chk({12'h0, io8_recovery_o}, (c == 0) ? 16'h8 : 16'(6 - c));
      chk({15'h0, mem_io16_wait_o}, {15'h0, !c[0]});
    end
    for (int s = 0; s < 4; s++) begin
      wix(8'h50, {2'(s), 6'h00});
      chk({14'h0, isa_clock_sel_o}, 16'(s));
      n = 0;
      for (int k = 0; k < 12; k++) begin
        osc_tick_i = (s == 0) && (k == 4 || k == 8);
        @(negedge clock_i);
        n += int'(isa_bus_clock_en_o);
      end
      chk(16'(n), (s == 0) ? 16'h2 : (s == 3) ? 16'h0 : 16'(s + 2));
    end
    chk({15'h0, flash_write_allowed_o}, 16'h1);
    wix(8'h50, 8'h20);
    wix(8'h50, 8'h00);
    chk({15'h0, flash_write_allowed_o}, 16'h0);
    wix(8'h50, 8'h09);
    wix(8'h53, 8'hFF);
    rdc(1'b0, 16'h0023, 8'h01);
    chk({13'h0, upper_cmos_enable_o, isa_slew_strong_o, pci_buffer_strong_o}, 16'h7);
    for (int k = 0; k < 18; k++) begin
      ch = 3'(k >> 1);
      en = k < 16;
      hit = en && ch != 3'h4;
      acc(1'b1, 1'b1, 16'h0062, k[0] ? {en, ch, 4'h0} : {4'h0, en, ch});
      onboard_dma_req0_i = !k[0];
      onboard_dma_req1_i = k[0];
      isa_dreq_i = 8'($urandom);
      slow = k[1];
      tick(5);
      e = isa_dreq_i;
      e[ch] = hit ? 1'b1 : e[ch];
      chk({8'h0, ctrl_dreq_o}, {8'h0, e});
      e = ctrl_dack_n_i;
      e[ch] = hit ? 1'b1 : e[ch];
      chk({8'h0, isa_dack_n_o}, {8'h0, e});
      v = {7'h0, k[0] ? onboard_dma_ack1_n_o : onboard_dma_ack0_n_o};
      chk({8'h0, v}, {15'h0, !hit || ctrl_dack_n_i[ch]});
    end
    disk_interrupt_i = 1'b1;
    for (int c = 0; c < 17; c++) begin
      acc(1'b1, 1'b1, 16'h0063, (c == 16) ? 8'h8F : 8'(c));
      chk(disk_irq_route_o, (c inside {[3:7], [9:12], 14, 15}) ? 16'h1 << c : 16'h0);
    end
    acc(1'b1, 1'b1, 16'h0065, 8'h00);
    rdc(1'b1, 16'h0065, 8'h00);
    chk({14'h0, arbiter_enable_o, ide_master_allow_o}, 16'h0);
    acc(1'b1, 1'b1, 16'h0065, 8'h80);
    acc(1'b1, 1'b1, 16'h0064, 8'hC0);
    acc(1'b1, 1'b1, 16'h006A, 8'h01);
    general_purpose_pin_i = 1'b1;
    tick(4);
    rdc(1'b1, 16'h006A, {5'h0, rtc_in_use_i, 2'h1});
    acc(1'b1, 1'b1, 16'h006A, 8'h11);
    rdc(1'b1, 16'h006A, {5'h2, rtc_in_use_i, 2'h0});
    chk({15'h0, arbiter_rotating_o}, 16'h1);
    acc(1'b1, 1'b1, 16'h0064, 8'h80);
    acc(1'b1, 1'b1, 16'h006A, 8'h11);
    general_purpose_pin_i = 1'b0;
    tick(4);
    rdc(1'b1, 16'h006A, {5'h2, rtc_in_use_i, 2'h1});
    acc(1'b1, 1'b1, 16'h0064, 8'hE2);
    tick(10);
    acc(1'b1, 1'b1, 16'h006A, 8'h11);
    general_purpose_pin_i = 1'b1;
    tick(1);
    general_purpose_pin_i = 1'b0;
    tick(10);
    rdc(1'b1, 16'h006A, {5'h2, rtc_in_use_i, 2'h0});
    general_purpose_pin_i = 1'b1;
    tick(20);
    rdc(1'b1, 16'h006A, {5'h2, rtc_in_use_i, 2'h1});
    acc(1'b1, 1'b1, 16'h0064, 8'h00);
    tick(1);
    chk({15'h0, general_purpose_pin_oe_o}, 16'h1);
    for (int k = 0; k < 4; k++) begin
      m = (k == 0) ? 16'h3 : (k == 1) ? 16'h7 : 16'hF;
      b = 16'($urandom) & ~m;
      acc(1'b1, 1'b1, 16'h0066, {b[7:2], (k == 2) ? 2'h3 : (k == 3) ? 2'h2 : 2'(k)});
      acc(1'b1, 1'b1, 16'h0067, b[15:8]);
      {io_cycle_valid_i, io_cycle_subtractive_i} = 2'h3;
      io_cycle_addr_i = b | (16'($urandom) & m);
      tick(1);
      chk({15'h0, general_purpose_pin_o}, {15'h0, k == 3});
      io_cycle_addr_i = b ^ (m + 16'h1);
      tick(1);
      chk({15'h0, general_purpose_pin_o}, 16'h1);
      io_cycle_valid_i = 1'b0;
    end
    end_of_test();
  end
endmodule

// ### design/system_io_misc_control_regs.sv
`timescale 1ns/1ps
module system_io_misc_control_regs #(
  parameter longint DEB_TICK = misc_ctrl_pkg::DEB_TICK_CYCLES,
  parameter int DMA_CHANNELS = 8
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire misc_ctrl_pkg::bus_req_t bus_req_i,
  output logic [7:0] bus_rdata_o,
  output logic bus_rvalid_o,
  input wire logic onboard_dma_req0_i,
  input wire logic onboard_dma_req1_i,
  output logic onboard_dma_ack0_n_o,
  output logic onboard_dma_ack1_n_o,
  input wire logic [DMA_CHANNELS-1:0] isa_dreq_i,
  input wire logic [DMA_CHANNELS-1:0] ctrl_dack_n_i,
  output logic [DMA_CHANNELS-1:0] ctrl_dreq_o,
  output logic [DMA_CHANNELS-1:0] isa_dack_n_o,
  input wire logic disk_interrupt_i,
  output logic [15:0] disk_irq_route_o,
  input wire logic general_purpose_pin_i,
  output logic general_purpose_pin_o,
  output logic general_purpose_pin_oe_o,
  input wire logic io_cycle_valid_i,
  input wire logic io_cycle_subtractive_i,
  input wire logic [15:0] io_cycle_addr_i,
  output logic arbiter_enable_o,
  output logic arbiter_rotating_o,
  output logic ide_master_allow_o,
  input wire logic rtc_in_use_i,
  output logic [15:0] irq_level_mode_o,
  input wire logic osc_tick_i,
  output logic isa_bus_clock_en_o,
  output logic [1:0] isa_clock_sel_o,
  output logic [3:0] io16_recovery_o,
  output logic [3:0] io8_recovery_o,
  output logic mem_io16_wait_o,
  output logic flash_write_allowed_o,
  output logic upper_cmos_enable_o,
  output logic isa_slew_strong_o,
  output logic pci_buffer_strong_o,
  input wire logic [7:0] cmos_index_i,
  input wire logic [15:0] irq_event_i,
  input wire logic nmi_event_i,
  output logic system_wake_o,
  output logic monitor_wake_o
);

  logic [7:0] dma_remap;
  logic [7:0] irq_remap;
  logic [7:0] gp_ctrl;
  logic [7:0] arb_en;
  logic [15:0] gp_decode;
  logic arb_rotating;
  logic gp_status;
  logic [15:0] trig_mode;
  logic [7:0] index_reg;
  logic [7:0] clk_flash;
  logic [7:0] recovery;
  logic [7:0] buf_cur;
  logic [7:0] scratch;
  logic [15:0] sys_wake_mask;
  logic [15:0] mon_wake_mask;
  logic flash_locked;
  logic [1:0] div_cnt;
  logic [31:0] tick_cnt;
  logic deb_tick;
  logic [3:0] deb_cnt;
  logic gp_raw_q;
  logic gp_filtered;
  logic gp_active_q;
  logic [7:0] next_rdata;

  wire cfg_wr = bus_req_i.cfg && bus_req_i.wr;
  wire io_wr = !bus_req_i.cfg && bus_req_i.wr;
  wire io_rd = !bus_req_i.cfg && bus_req_i.rd;
  wire [7:0] wd = bus_req_i.wdata;
  wire [15:0] ad = bus_req_i.addr;
  wire data_wr = io_wr && ad == misc_ctrl_pkg::PORT_DATA;

  // DMA pair routing.
  wire [2:0] code0 = dma_remap[2:0];
  wire [2:0] code1 = dma_remap[6:4];
  wire pair0_on = dma_remap[misc_ctrl_pkg::DMA0_EN_BIT] && code0 != misc_ctrl_pkg::DMA_CODE_OFF;
  wire pair1_on = dma_remap[misc_ctrl_pkg::DMA1_EN_BIT] && code1 != misc_ctrl_pkg::DMA_CODE_OFF;
  logic [DMA_CHANNELS-1:0] sel0;
  logic [DMA_CHANNELS-1:0] sel1;

  genvar ch;
  generate
    for (ch = 0; ch < DMA_CHANNELS; ch = ch + 1) begin : g_dma
      assign sel0[ch] = pair0_on && code0 == 3'(ch);
      assign sel1[ch] = pair1_on && code1 == 3'(ch) && !sel0[ch];
      assign ctrl_dreq_o[ch] = sel0[ch] ? onboard_dma_req0_i :
                               sel1[ch] ? onboard_dma_req1_i : isa_dreq_i[ch];
      assign isa_dack_n_o[ch] = (sel0[ch] || sel1[ch]) ? 1'b1 : ctrl_dack_n_i[ch];
    end
  endgenerate

  assign onboard_dma_ack0_n_o = !(|(sel0 & ~ctrl_dack_n_i));
  assign onboard_dma_ack1_n_o = !(|(sel1 & ~ctrl_dack_n_i));

  wire irq_remap_on = !irq_remap[misc_ctrl_pkg::IRQ_DIS_BIT];
  wire irq_code_ok = misc_ctrl_pkg::IRQ_VALID[irq_remap[3:0]];
  assign disk_irq_route_o = (irq_remap_on && irq_code_ok && disk_interrupt_i) ?
                            (16'h0001 << irq_remap[3:0]) : 16'h0000;

  wire gp_input_mode = gp_ctrl[misc_ctrl_pkg::GP_INPUT_BIT];
  wire gp_level_active = gp_ctrl[misc_ctrl_pkg::GP_POL_BIT] ? general_purpose_pin_i :
                         !general_purpose_pin_i;
  wire gp_active = gp_input_mode && (gp_ctrl[misc_ctrl_pkg::GP_DEB_BIT] ? gp_filtered :
                   gp_level_active);
  wire [3:0] deb_need = (gp_ctrl[3:0] < misc_ctrl_pkg::DEB_MIN_COUNT) ? 4'h1 :
                        gp_ctrl[3:0] - 4'h1;

  wire [1:0] dec_mask = gp_decode[1:0];
  wire [15:0] addr_ign = (dec_mask == misc_ctrl_pkg::MASK_A1) ? 16'h0003 :
                         (dec_mask == misc_ctrl_pkg::MASK_A2) ? 16'h0007 : 16'h000F;
  wire gp_hit = !gp_input_mode && dec_mask != misc_ctrl_pkg::MASK_OFF && io_cycle_valid_i &&
                io_cycle_subtractive_i &&
                ((io_cycle_addr_i & ~addr_ign) == ({gp_decode[15:2], 2'h0} & ~addr_ign));

  assign arbiter_enable_o = arb_en[misc_ctrl_pkg::ARB_EN_BIT];
  assign ide_master_allow_o = arb_en[misc_ctrl_pkg::ARB_EN_BIT];
  assign arbiter_rotating_o = arb_rotating;
  assign irq_level_mode_o = trig_mode;

  assign isa_clock_sel_o = clk_flash[7:6];
  wire div_last = (clk_flash[7:6] == misc_ctrl_pkg::CLK_DIV3) ?
                  div_cnt == misc_ctrl_pkg::DIV3_LAST : div_cnt == misc_ctrl_pkg::DIV4_LAST;
  assign isa_bus_clock_en_o = (clk_flash[7:6] == misc_ctrl_pkg::CLK_OSC) ? osc_tick_i :
                              (clk_flash[7:6] == misc_ctrl_pkg::CLK_DIV4 ||
                               clk_flash[7:6] == misc_ctrl_pkg::CLK_DIV3) && div_last;

  assign io16_recovery_o = misc_ctrl_pkg::REC16_TABLE[{recovery[7:6], 2'h0} +: 4];
  assign io8_recovery_o = misc_ctrl_pkg::REC8_TABLE[{recovery[5:4], 2'h0} +: 4];
  assign mem_io16_wait_o = !recovery[misc_ctrl_pkg::WAIT16_BIT];
  assign flash_write_allowed_o = !clk_flash[misc_ctrl_pkg::FLASH_LOCK_BIT] &&
                                 !(flash_locked && !clk_flash[misc_ctrl_pkg::FLASH_OVR_BIT]);
  assign upper_cmos_enable_o = clk_flash[3];
  assign isa_slew_strong_o = clk_flash[0];
  assign pci_buffer_strong_o = buf_cur[0];

  wire [15:0] sys_src = {irq_event_i[15:3], gp_active, irq_event_i[1], nmi_event_i};
  wire [15:0] mon_src = {irq_event_i[15:1], nmi_event_i};
  assign system_wake_o = |(sys_src & ~sys_wake_mask);
  assign monitor_wake_o = |(mon_src & ~mon_wake_mask);

  wire gp_rise = gp_active && !gp_active_q && arbiter_enable_o;
  wire st_wr = cfg_wr && ad == misc_ctrl_pkg::OFF_GP_STATUS;

  wire [7:0] idx_rdata =
    (index_reg == misc_ctrl_pkg::IDX_CLK_FLASH) ? clk_flash :
    (index_reg == misc_ctrl_pkg::IDX_RECOVERY) ? recovery :
    (index_reg == misc_ctrl_pkg::IDX_BUF_CUR) ? buf_cur :
    (index_reg == misc_ctrl_pkg::IDX_SCRATCH) ? scratch :
    (index_reg == misc_ctrl_pkg::IDX_CMOS_MIRROR) ? cmos_index_i :
    (index_reg == misc_ctrl_pkg::IDX_SYS_WAKE_LO) ? sys_wake_mask[7:0] :
    (index_reg == misc_ctrl_pkg::IDX_SYS_WAKE_HI) ? sys_wake_mask[15:8] :
    (index_reg == misc_ctrl_pkg::IDX_MON_WAKE_LO) ? mon_wake_mask[7:0] :
    (index_reg == misc_ctrl_pkg::IDX_MON_WAKE_HI) ? mon_wake_mask[15:8] : 8'h00;

  wire [7:0] status_rd = {3'h0, arb_rotating, 1'b0, rtc_in_use_i, 1'b0, gp_status};

  always_comb begin
    next_rdata = 8'h00;
    if (bus_req_i.cfg) begin
      unique case (ad)
        misc_ctrl_pkg::OFF_DMA_REMAP: next_rdata = dma_remap;
        misc_ctrl_pkg::OFF_IRQ_REMAP: next_rdata = {irq_remap[7], 3'h0, irq_remap[3:0]};
        misc_ctrl_pkg::OFF_GP_CTRL: next_rdata = {gp_ctrl[7:5], 1'b0, gp_ctrl[3:0]};
        misc_ctrl_pkg::OFF_ARB_EN: next_rdata = {arb_en[7], 7'h00};
        misc_ctrl_pkg::OFF_GP_DEC_LO: next_rdata = gp_decode[7:0];
        misc_ctrl_pkg::OFF_GP_DEC_HI: next_rdata = gp_decode[15:8];
        misc_ctrl_pkg::OFF_GP_STATUS: next_rdata = status_rd;
        default: next_rdata = 8'h00;
      endcase
    end else begin
      unique case (ad)
        misc_ctrl_pkg::PORT_INDEX: next_rdata = index_reg;
        misc_ctrl_pkg::PORT_DATA: next_rdata = idx_rdata;
        misc_ctrl_pkg::PORT_TRIG_LO: next_rdata = trig_mode[7:0] & misc_ctrl_pkg::IRQ_VALID[7:0];
        misc_ctrl_pkg::PORT_TRIG_HI: next_rdata = trig_mode[15:8] &
                                                  misc_ctrl_pkg::IRQ_VALID[15:8];
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      bus_rdata_o <= misc_ctrl_pkg::RST_BYTE;
      bus_rvalid_o <= 1'b0;
    end else begin
      bus_rdata_o <= bus_req_i.rd ? next_rdata : bus_rdata_o;
      bus_rvalid_o <= bus_req_i.rd;
    end
  end

  // Configuration-space registers.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      dma_remap <= misc_ctrl_pkg::RST_DMA_REMAP;
      irq_remap <= misc_ctrl_pkg::RST_IRQ_REMAP;
      gp_ctrl <= misc_ctrl_pkg::RST_GP_CTRL;
      arb_en <= misc_ctrl_pkg::RST_ARB_EN;
      gp_decode <= misc_ctrl_pkg::RST_GP_DEC;
      arb_rotating <= 1'b0;
    end else if (cfg_wr) begin
      if (ad == misc_ctrl_pkg::OFF_DMA_REMAP) dma_remap <= wd;
      if (ad == misc_ctrl_pkg::OFF_IRQ_REMAP) irq_remap <= wd;
      if (ad == misc_ctrl_pkg::OFF_GP_CTRL) gp_ctrl <= wd;
      if (ad == misc_ctrl_pkg::OFF_ARB_EN) arb_en <= wd;
      if (ad == misc_ctrl_pkg::OFF_GP_DEC_LO) gp_decode[7:0] <= wd;
      if (ad == misc_ctrl_pkg::OFF_GP_DEC_HI) gp_decode[15:8] <= wd;
      if (ad == misc_ctrl_pkg::OFF_GP_STATUS) arb_rotating <= wd[misc_ctrl_pkg::ST_ROT_BIT];
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      gp_status <= 1'b0;
    end else if (gp_rise) begin
      gp_status <= 1'b1;
    end else if (st_wr && wd[misc_ctrl_pkg::ST_GP_BIT]) begin
      gp_status <= 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      trig_mode <= misc_ctrl_pkg::RST_TRIG;
    end else if (io_wr && ad == misc_ctrl_pkg::PORT_TRIG_LO) begin
      trig_mode[7:0] <= wd & misc_ctrl_pkg::IRQ_VALID[7:0];
    end else if (io_wr && ad == misc_ctrl_pkg::PORT_TRIG_HI) begin
      trig_mode[15:8] <= wd & misc_ctrl_pkg::IRQ_VALID[15:8];
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      index_reg <= misc_ctrl_pkg::RST_BYTE;
      clk_flash <= misc_ctrl_pkg::RST_BYTE;
      recovery <= misc_ctrl_pkg::RST_BYTE;
      buf_cur <= misc_ctrl_pkg::RST_BYTE;
      scratch <= misc_ctrl_pkg::RST_BYTE;
      sys_wake_mask <= 16'h0000;
      mon_wake_mask <= 16'h0000;
    end else begin
      if (io_wr && ad == misc_ctrl_pkg::PORT_INDEX) index_reg <= wd;
      if (data_wr && index_reg == misc_ctrl_pkg::IDX_CLK_FLASH) clk_flash <= wd;
      if (data_wr && index_reg == misc_ctrl_pkg::IDX_RECOVERY) recovery <= wd;
      if (data_wr && index_reg == misc_ctrl_pkg::IDX_BUF_CUR) buf_cur <= {7'h00, wd[0]};
      if (data_wr && index_reg == misc_ctrl_pkg::IDX_SCRATCH) scratch <= wd;
      if (data_wr && index_reg == misc_ctrl_pkg::IDX_SYS_WAKE_LO) sys_wake_mask[7:0] <= wd;
      if (data_wr && index_reg == misc_ctrl_pkg::IDX_SYS_WAKE_HI) sys_wake_mask[15:8] <= wd;
      if (data_wr && index_reg == misc_ctrl_pkg::IDX_MON_WAKE_LO) mon_wake_mask[7:0] <= wd;
      if (data_wr && index_reg == misc_ctrl_pkg::IDX_MON_WAKE_HI) mon_wake_mask[15:8] <= wd;
    end
  end

  // lock latch
  // The latch only drops at reset, so a later clear of the lock bit reopens flashing only while the override bit (FLASH_OVR_BIT) is set.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      flash_locked <= 1'b0;
    end else if (clk_flash[misc_ctrl_pkg::FLASH_LOCK_BIT] &&
                 !clk_flash[misc_ctrl_pkg::FLASH_OVR_BIT]) begin
      flash_locked <= 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i || div_last) begin
      div_cnt <= 2'h0;
    end else begin
      div_cnt <= div_cnt + 2'h1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i || deb_tick) begin
      tick_cnt <= 32'h0;
    end else begin
      tick_cnt <= tick_cnt + 32'h1;
    end
  end
  assign deb_tick = tick_cnt == 32'(DEB_TICK - 1);

  // debounce filter
  // A bounce restarts the count but not tick_cnt, so the filtered level changes on the deb_need-th deb_tick after it, the first 1 to DEB_TICK cycles later.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      gp_raw_q <= 1'b0;
      gp_filtered <= 1'b0;
      deb_cnt <= 4'h0;
      gp_active_q <= 1'b0;
    end else begin
      gp_raw_q <= gp_level_active;
      gp_active_q <= gp_active;
      if (gp_level_active != gp_raw_q || gp_level_active == gp_filtered) begin
        deb_cnt <= 4'h0;
      end else if (deb_tick) begin
        if (deb_cnt + 4'h1 >= deb_need) begin
          gp_filtered <= gp_level_active;
          deb_cnt <= 4'h0;
        end else begin
          deb_cnt <= deb_cnt + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      general_purpose_pin_o <= 1'b1;
      general_purpose_pin_oe_o <= 1'b0;
    end else begin
      general_purpose_pin_o <= !gp_hit;
      general_purpose_pin_oe_o <= !gp_input_mode;
    end
  end

endmodule

// ### shared/misc_ctrl_pkg.sv
package misc_ctrl_pkg;

  // Bus request carried from the host bridge into the register bank.
  typedef struct packed {
    logic cfg;
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } bus_req_t;

  // Configuration-space offsets.
  localparam logic [15:0] OFF_DMA_REMAP = 16'h0062;
  localparam logic [15:0] OFF_IRQ_REMAP = 16'h0063;
  localparam logic [15:0] OFF_GP_CTRL = 16'h0064;
  localparam logic [15:0] OFF_ARB_EN = 16'h0065;
  localparam logic [15:0] OFF_GP_DEC_LO = 16'h0066;
  localparam logic [15:0] OFF_GP_DEC_HI = 16'h0067;
  localparam logic [15:0] OFF_GP_STATUS = 16'h006A;

  // I/O-space ports.
  localparam logic [15:0] PORT_INDEX = 16'h0022;
  localparam logic [15:0] PORT_DATA = 16'h0023;
  localparam logic [15:0] PORT_TRIG_LO = 16'h04D0;
  localparam logic [15:0] PORT_TRIG_HI = 16'h04D1;

  // Indexed internal registers.
  localparam logic [7:0] IDX_CLK_FLASH = 8'h50;
  localparam logic [7:0] IDX_RECOVERY = 8'h51;
  localparam logic [7:0] IDX_BUF_CUR = 8'h53;
  localparam logic [7:0] IDX_SCRATCH = 8'h54;
  localparam logic [7:0] IDX_CMOS_MIRROR = 8'h55;
  localparam logic [7:0] IDX_SYS_WAKE_LO = 8'h58;
  localparam logic [7:0] IDX_SYS_WAKE_HI = 8'h59;
  localparam logic [7:0] IDX_MON_WAKE_LO = 8'h5A;
  localparam logic [7:0] IDX_MON_WAKE_HI = 8'h5B;

  // Reset values.
  localparam logic [7:0] RST_DMA_REMAP = 8'h00;
  localparam logic [7:0] RST_IRQ_REMAP = 8'h80;
  localparam logic [7:0] RST_GP_CTRL = 8'h80;
  localparam logic [7:0] RST_ARB_EN = 8'h80;
  localparam logic [15:0] RST_GP_DEC = 16'h0002;
  localparam logic [15:0] RST_TRIG = 16'h0000;
  localparam logic [7:0] RST_BYTE = 8'h00;

  // Field positions and codes.
  localparam int DMA0_EN_BIT = 3;
  localparam int DMA1_EN_BIT = 7;
  localparam logic [2:0] DMA_CODE_OFF = 3'h4;
  localparam int IRQ_DIS_BIT = 7;
  localparam int GP_INPUT_BIT = 7;
  localparam int GP_POL_BIT = 6;
  localparam int GP_DEB_BIT = 5;
  localparam int ARB_EN_BIT = 7;
  localparam int ST_ROT_BIT = 4;
  localparam int ST_RTC_BIT = 2;
  localparam int ST_GP_BIT = 0;
  localparam int FLASH_LOCK_BIT = 5;
  localparam int FLASH_OVR_BIT = 2;
  localparam int WAIT16_BIT = 2;
  localparam int GP_WAKE_BIT = 2;
  localparam logic [1:0] MASK_A1 = 2'h0;
  localparam logic [1:0] MASK_A2 = 2'h1;
  localparam logic [1:0] MASK_OFF = 2'h2;
  localparam logic [1:0] CLK_OSC = 2'h0;
  localparam logic [1:0] CLK_DIV4 = 2'h1;
  localparam logic [1:0] CLK_DIV3 = 2'h2;
  localparam logic [1:0] DIV4_LAST = 2'h3;
  localparam logic [1:0] DIV3_LAST = 2'h2;
  localparam logic [3:0] DEB_MIN_COUNT = 4'h2;

  // IRQ lines that may be remapped or switched to level mode.
  localparam logic [15:0] IRQ_VALID = 16'hDEF8;

  // Recovery lookup, packed four 4-bit counts, code 0 in the low nibble.
  localparam logic [15:0] REC16_TABLE = 16'h2345;
  localparam logic [15:0] REC8_TABLE = 16'h3458;

  // Debounce tick of 0.6 s at the 10 MHz clock.
  localparam longint CLOCK_HZ = 10000000;
  localparam longint DEB_UNIT_MS = 600;
  localparam longint DEB_TICK_CYCLES = CLOCK_HZ * DEB_UNIT_MS / 1000;

endpackage
